// ---- tb/test_usb_power_mode_and_supply_irq.sv ----
// self-checking bench for the usb power mode and supply-change bank
// assumes upms_pkg is compiled first; design asserts live in the design
`timescale 1ns/1ps

module test_usb_power_mode_and_supply_irq;
   logic mclk, rst_n, regWrEn, regRdEn, regRdValid;
   logic [7:0] regAddr;
   logic [15:0] regWrData, regRdData, rdWord;
   logic usbFb, wallFb, battFb, overCur, underV, bootFail, m2s, strap;
   logic swOpen, srcRole, limHigh, usbIrq, supIrq;
   logic [2:0] flip, mask;
   int num_errors, checked;

   upms_top dut (.mclk(mclk), .rst_n(rst_n), .regAddr(regAddr),
      .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
      .regRdData(regRdData), .regRdValid(regRdValid),
      .usbPresentFeedback(usbFb), .wallPresentFeedback(wallFb),
      .batteryPresentFeedback(battFb), .usbOvercurrent(overCur),
      .lineUnderVoltage(underV), .bootHysteresisFail(bootFail),
      .usbMasterToSlave(m2s), .configSinkHighCurrent(strap),
      .usbSwitchOpen(swOpen), .usbPowerSourceRole(srcRole),
      .currentLimitHigh(limHigh), .usbIrq(usbIrq),
      .supplyChangeIrq(supIrq));

   // free-running 125 MHz clock
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   task automatic tally_and_finish;
      if (num_errors == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic waitc(input int n);
      repeat (n) @(posedge mclk);
   endtask

   // one-cycle write strobe; the next call lets an edge pass first
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge mclk);
      regAddr <= a;
      regWrData <= d;
      regWrEn <= 1'b1;
      @(posedge mclk);
      regWrEn <= 1'b0;
   endtask

   // read answer is registered, so sample just after the next edge
   task automatic rd(input logic [7:0] a);
      @(posedge mclk);
      regAddr <= a;
      regRdEn <= 1'b1;
      @(posedge mclk);
      regRdEn <= 1'b0;
      #1;
      chk("rdValid", regRdValid, 1'b1);
      rdWord = regRdData;
   endtask

   function automatic logic [15:0] ctrlExp(input logic s, r, hi, lo);
      return {1'b0, s, r, 1'b0, hi, 1'b0, lo, 9'h000};
   endfunction

   function automatic logic [15:0] chgExp(input logic [2:0] f);
      return {f, 13'h0000};
   endfunction

   // watchdog, generous against the few hundred cycles expected
   initial begin
      waitc(5000);
      num_errors++;
      tally_and_finish();
   end

   // main sequence
   initial begin
      {rst_n, regWrEn, regRdEn, m2s, underV, bootFail, overCur} = 7'h00;
      {usbFb, wallFb, battFb} = 3'h0;
      regAddr = 8'h00;
      regWrData = 16'h0000;
      strap = 1'b1;
      void'($urandom(37108));
      waitc(10);
      rst_n <= 1'b1;
      waitc(3);
      rd(upms_pkg::ADDR_SYS_CTRL_TWO);
      chk("ctrl reset", rdWord, ctrlExp(0, 0, 0, 1));
      chk("limit reset", limHigh, 1'b1);
      rd(upms_pkg::ADDR_INT_STAT_TWO_MASK);
      chk("oc mask reset", rdWord, 16'h0000);
      rd(upms_pkg::ADDR_CMP_INT_MASK);
      chk("chg mask reset", rdWord, 16'h0000);
      rd(8'h55);
      chk("unmapped", rdWord, 16'h0000);
      // every mix of suspend, role and source current bit; sink bit follows suspend
      for (int i = 0; i < 8; i++) begin
         wr(upms_pkg::ADDR_SYS_CTRL_TWO, ctrlExp(i[0], i[1], i[2], i[0]));
         waitc(2);
         chk("switch", swOpen, i[0]);
         chk("role", srcRole, i[1]);
         chk("limit", limHigh, i[1] ? i[2] : i[0]);
      end
      // state machine drops back to sink role
      @(posedge mclk);
      m2s <= 1'b1;
      @(posedge mclk);
      m2s <= 1'b0;
      waitc(2);
      chk("role drop", srcRole, 1'b0);
      rd(upms_pkg::ADDR_SYS_CTRL_TWO);
      chk("ctrl drop", rdWord, ctrlExp(1, 0, 1, 1));
      // undervoltage, then boot failure, force the clears
      for (int k = 0; k < 2; k++) begin
         wr(upms_pkg::ADDR_SYS_CTRL_TWO, ctrlExp(1, 1, 1, 1));
         if (k == 0) underV <= 1'b1;
         else bootFail <= 1'b1;
         waitc(5);
         underV <= 1'b0;
         bootFail <= 1'b0;
         waitc(4);
         chk("switch forced", swOpen, 1'b0);
         rd(upms_pkg::ADDR_SYS_CTRL_TWO);
         chk("ctrl forced", rdWord, ctrlExp(0, 1, 1, 0));
      end
      // over-current unmasked then masked; the fall must not latch
      for (int m = 0; m < 2; m++) begin
         wr(upms_pkg::ADDR_INT_STAT_TWO_MASK, m ? 16'h0400 : 16'h0000);
         overCur <= 1'b1;
         waitc(6);
         chk("usbIrq", usbIrq, m == 0);
         chk("supply quiet", supIrq, 1'b0);
         rd(upms_pkg::ADDR_INT_STAT_TWO);
         chk("oc status", rdWord, 16'h0400);
         overCur <= 1'b0;
         waitc(6);
         chk("usbIrq clear", usbIrq, 1'b0);
         rd(upms_pkg::ADDR_INT_STAT_TWO);
         chk("oc no fall", rdWord, 16'h0000);
      end
      // status register ignores writes
      wr(upms_pkg::ADDR_CMP_INT_STAT, 16'hffff);
      rd(upms_pkg::ADDR_CMP_INT_STAT);
      chk("chg write", rdWord, 16'h0000);
      // presence toggles: all rise, all fall masked, then random
      for (int n = 0; n < 12; n++) begin
         flip = 3'($urandom);
         mask = 3'($urandom);
         if (n < 2) flip = 3'h7;
         if (n < 2) mask = n ? 3'h7 : 3'h0;
         wr(upms_pkg::ADDR_CMP_INT_MASK, {mask, 13'h0000});
         usbFb <= usbFb ^ flip[2];
         wallFb <= wallFb ^ flip[1];
         battFb <= battFb ^ flip[0];
         waitc(6);
         chk("supplyIrq", supIrq, |(flip & ~mask));
         chk("usb quiet", usbIrq, 1'b0);
         rd(upms_pkg::ADDR_CMP_INT_STAT);
         chk("chg status", rdWord, chgExp(flip));
         waitc(2);
         chk("supply clear", supIrq, 1'b0);
      end
      // second reset, strap low; supplies already present read as edges
      @(posedge mclk);
      strap <= 1'b0;
      rst_n <= 1'b0;
      waitc(10);
      rst_n <= 1'b1;
      waitc(6);
      flip = {usbFb, wallFb, battFb};
      chk("supply reset", supIrq, |flip);
      rd(upms_pkg::ADDR_SYS_CTRL_TWO);
      chk("ctrl reset 2", rdWord, ctrlExp(0, 0, 0, 0));
      chk("limit reset 2", limHigh, 1'b0);
      rd(upms_pkg::ADDR_INT_STAT_TWO_MASK);
      chk("oc mask reset 2", rdWord, 16'h0000);
      rd(upms_pkg::ADDR_CMP_INT_MASK);
      chk("chg mask reset 2", rdWord, 16'h0000);
      rd(upms_pkg::ADDR_CMP_INT_STAT);
      chk("chg after reset", rdWord, chgExp(flip));
      tally_and_finish();
   end
endmodule

// ---- verilog/upms_pkg.sv ----
// constants for the usb power mode and supply-change register bank
// assumes a 16-bit register port with 8-bit register addresses
package upms_pkg;

   // register addresses at their printed offsets
   localparam logic [7:0] ADDR_SYS_CTRL_TWO = 8'h04;
   localparam logic [7:0] ADDR_INT_STAT_TWO = 8'h1a;
   localparam logic [7:0] ADDR_CMP_INT_STAT = 8'h1f;
   localparam logic [7:0] ADDR_INT_STAT_TWO_MASK = 8'h22;
   localparam logic [7:0] ADDR_CMP_INT_MASK = 8'h27;

   // system control two field positions
   localparam int SUSPEND_BIT = 14;
   localparam int SOURCE_ROLE_BIT = 13;
   localparam int SOURCE_HIGH_BIT = 11;
   localparam int SINK_HIGH_BIT = 9;

   // interrupt status two and its mask
   localparam int OVERCURRENT_BIT = 10;

   // comparator interrupt status and mask
   localparam int USB_CHANGE_BIT = 15;
   localparam int WALL_CHANGE_BIT = 14;
   localparam int BATT_CHANGE_BIT = 13;

   // synchroniser lanes for the asynchronous inputs
   localparam int LANE_USB_PRESENT_FEEDBACK = 0;
   localparam int LANE_WALL_PRESENT_FEEDBACK = 1;
   localparam int LANE_BATTERY_PRESENT_FEEDBACK = 2;
   localparam int LANE_OVERCURRENT = 3;
   localparam int LANE_UVLO = 4;
   localparam int LANE_BOOT_FAIL = 5;
   localparam int SYNC_LANES = 6;

   // reset values
   localparam logic [15:0] REG_ZERO = 16'h0000;
   localparam logic [2:0] CHANGE_RESET = 3'h0;

endpackage

// ---- verilog/upms_top.sv ----
// usb supply mode control and supply-change interrupt register bank
// assumes a simple register port from the control interface, all
// analogue status inputs asynchronous, role-change pulse on mclk
//
// What this block does
// - suspend bit 14 opens usb switch
// - suspend cleared on reset, uvlo, boot fail
// - bit 13 selects usb sink or source role
// - role bit cleared on reset, master-to-slave
// - bit 11 picks source role current limit
// - bit 9 sink limit, strap reset, forced clear
// - active role's bit sets monitor threshold
// - overcurrent status latches rising edge, read-clears
// - overcurrent mask blocks usb interrupt, resets zero
// - usb interrupt sourced only by overcurrent
// - supply interrupt combines three presence changes
// - presence events latch on both edges
// - change bits 15..13, each cleared by read
// - mask bits 15..13 block supply interrupt
// - suspend disconnects usb, battery takes over
`timescale 1ns/1ps

module upms_top (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // register port
   input wire logic [7:0] regAddr,
   input wire logic regWrEn,
   input wire logic [15:0] regWrData,
   input wire logic regRdEn,
   output logic [15:0] regRdData,
   output logic regRdValid,
   // supply feedback and fault inputs, asynchronous
   input wire logic usbPresentFeedback,
   input wire logic wallPresentFeedback,
   input wire logic batteryPresentFeedback,
   input wire logic usbOvercurrent,
   input wire logic lineUnderVoltage,
   input wire logic bootHysteresisFail,
   // on-chip usb state machine, on mclk
   input wire logic usbMasterToSlave,
   // configuration-mode strap for the sink role current limit
   input wire logic configSinkHighCurrent,
   // controls to the supply path
   output logic usbSwitchOpen,
   output logic usbPowerSourceRole,
   output logic currentLimitHigh,
   // first-level interrupts
   output logic usbIrq,
   output logic supplyChangeIrq
);

   logic [upms_pkg::SYNC_LANES-1:0] syncMeta;
   logic [upms_pkg::SYNC_LANES-1:0] syncOut;
   logic [upms_pkg::SYNC_LANES-1:0] syncPrev;
   logic sourceRoleHighCurrent;
   logic sinkRoleHighCurrent;
   logic usbOvercurrentEvent;
   logic usbOvercurrentMask;
   logic [2:0] presenceChange;
   logic [2:0] presenceMask;
   logic forceClear;
   logic ocRise;
   logic [2:0] fbToggle;
   logic wrSysCtrl;
   logic wrIstMask;
   logic wrCmpMask;
   logic rdIst;
   logic rdCmp;
   logic next_usbOvercurrentEvent;
   logic [2:0] next_presenceChange;
   logic [15:0] next_regRdData;

   // two-stage synchroniser; only the second stage feeds logic
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         syncMeta <= '0;
         syncOut <= '0;
      end else begin
         syncMeta <= {bootHysteresisFail, lineUnderVoltage,
                      usbOvercurrent, batteryPresentFeedback,
                      wallPresentFeedback, usbPresentFeedback};
         syncOut <= syncMeta;
      end
   end

   // previous synchronised value for edge detection
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         syncPrev <= '0;
      end else begin
         syncPrev <= syncOut;
      end
   end

   // edge and access decode
   assign ocRise = syncOut[upms_pkg::LANE_OVERCURRENT] &
                   ~syncPrev[upms_pkg::LANE_OVERCURRENT];
   assign fbToggle = syncOut[2:0] ^ syncPrev[2:0];
   assign forceClear = syncOut[upms_pkg::LANE_UVLO] |
                       syncOut[upms_pkg::LANE_BOOT_FAIL];
   assign wrSysCtrl = regWrEn && (regAddr == upms_pkg::ADDR_SYS_CTRL_TWO);
   assign wrIstMask = regWrEn &&
                      (regAddr == upms_pkg::ADDR_INT_STAT_TWO_MASK);
   assign wrCmpMask = regWrEn && (regAddr == upms_pkg::ADDR_CMP_INT_MASK);
   assign rdIst = regRdEn && (regAddr == upms_pkg::ADDR_INT_STAT_TWO);
   assign rdCmp = regRdEn && (regAddr == upms_pkg::ADDR_CMP_INT_STAT);

   // suspend bit: the fault clear outranks a software write
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         usbSwitchOpen <= 1'b0;
      end else if (forceClear) begin
         usbSwitchOpen <= 1'b0;
      end else if (wrSysCtrl) begin
         usbSwitchOpen <=
            regWrData[upms_pkg::SUSPEND_BIT];
      end
   end

   // role bit: dropping back to slave wins over a write
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         usbPowerSourceRole <= 1'b0;
      end else if (usbMasterToSlave) begin
         usbPowerSourceRole <= 1'b0;
      end else if (wrSysCtrl) begin
         usbPowerSourceRole <=
            regWrData[upms_pkg::SOURCE_ROLE_BIT];
      end
   end

   // source role current mode
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sourceRoleHighCurrent <= 1'b0;
      end else if (wrSysCtrl) begin
         sourceRoleHighCurrent <=
            regWrData[upms_pkg::SOURCE_HIGH_BIT];
      end
   end

   // sink role current mode; strap is sampled while reset is held,
   // which is safe since the reset is synchronous
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sinkRoleHighCurrent <= configSinkHighCurrent;
      end else if (forceClear) begin
         sinkRoleHighCurrent <= 1'b0;
      end else if (wrSysCtrl) begin
         sinkRoleHighCurrent <=
            regWrData[upms_pkg::SINK_HIGH_BIT];
      end
   end

   // monitor threshold follows the active role, one cycle behind
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         currentLimitHigh <= 1'b0;
      end else begin
         currentLimitHigh <= usbPowerSourceRole ? sourceRoleHighCurrent :
                             sinkRoleHighCurrent;
      end
   end

   // sticky status: a new event beats the read that clears it
   always_comb begin
      next_usbOvercurrentEvent = ocRise |
                                 (usbOvercurrentEvent & ~rdIst);
      next_presenceChange = fbToggle |
                            (presenceChange & ~{3{rdCmp}});
   end

   // status flops latch regardless of mask
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         usbOvercurrentEvent <= 1'b0;
         presenceChange <= upms_pkg::CHANGE_RESET;
      end else begin
         usbOvercurrentEvent <= next_usbOvercurrentEvent;
         presenceChange <= next_presenceChange;
      end
   end

   // mask registers
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         usbOvercurrentMask <= 1'b0;
         presenceMask <= upms_pkg::CHANGE_RESET;
      end else begin
         if (wrIstMask) begin
            usbOvercurrentMask <= regWrData[upms_pkg::OVERCURRENT_BIT];
         end
         if (wrCmpMask) begin
            presenceMask <= {regWrData[upms_pkg::BATT_CHANGE_BIT],
                             regWrData[upms_pkg::WALL_CHANGE_BIT],
                             regWrData[upms_pkg::USB_CHANGE_BIT]};
         end
      end
   end

   // first-level interrupts, registered from the current status
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         usbIrq <= 1'b0;
         supplyChangeIrq <= 1'b0;
      end else begin
         usbIrq <=
            usbOvercurrentEvent & ~usbOvercurrentMask;
         supplyChangeIrq <=
            |(presenceChange & ~presenceMask);
      end
   end

   // read mux; unused and unmapped bits read as zero
   always_comb begin
      next_regRdData = upms_pkg::REG_ZERO;
      case (regAddr)
         upms_pkg::ADDR_SYS_CTRL_TWO: begin
            next_regRdData[upms_pkg::SUSPEND_BIT] = usbSwitchOpen;
            next_regRdData[upms_pkg::SOURCE_ROLE_BIT] = usbPowerSourceRole;
            next_regRdData[upms_pkg::SOURCE_HIGH_BIT] = sourceRoleHighCurrent;
            next_regRdData[upms_pkg::SINK_HIGH_BIT] = sinkRoleHighCurrent;
         end
         upms_pkg::ADDR_INT_STAT_TWO: begin
            next_regRdData[upms_pkg::OVERCURRENT_BIT] = usbOvercurrentEvent;
         end
         upms_pkg::ADDR_CMP_INT_STAT: begin
            next_regRdData[upms_pkg::USB_CHANGE_BIT] = presenceChange[0];
            next_regRdData[upms_pkg::WALL_CHANGE_BIT] = presenceChange[1];
            next_regRdData[upms_pkg::BATT_CHANGE_BIT] = presenceChange[2];
         end
         upms_pkg::ADDR_INT_STAT_TWO_MASK: begin
            next_regRdData[upms_pkg::OVERCURRENT_BIT] = usbOvercurrentMask;
         end
         upms_pkg::ADDR_CMP_INT_MASK: begin
            next_regRdData[upms_pkg::USB_CHANGE_BIT] = presenceMask[0];
            next_regRdData[upms_pkg::WALL_CHANGE_BIT] = presenceMask[1];
            next_regRdData[upms_pkg::BATT_CHANGE_BIT] = presenceMask[2];
         end
         default: begin
            next_regRdData = upms_pkg::REG_ZERO;
         end
      endcase
   end

   // read data stands until the next read
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         regRdData <= upms_pkg::REG_ZERO;
         regRdValid <= 1'b0;
      end else begin
         regRdValid <= regRdEn;
         if (regRdEn) begin
            regRdData <= next_regRdData;
         end
      end
   end

   // checks on the logic above
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   a_suspend_force: assert property (
      forceClear |=> !usbSwitchOpen && !sinkRoleHighCurrent)
      else $error("suspend or sink limit not cleared by fault");

   a_suspend_write: assert property (
      wrSysCtrl && !forceClear |=>
         usbSwitchOpen == $past(regWrData[upms_pkg::SUSPEND_BIT]))
      else $error("suspend bit did not take written value");

   a_role_drop: assert property (
      usbMasterToSlave |=> !usbPowerSourceRole)
      else $error("role bit not cleared on return to slave");

   a_limit_follow: assert property (
      usbPowerSourceRole && sourceRoleHighCurrent && !wrSysCtrl &&
      !usbMasterToSlave |=> currentLimitHigh)
      else $error("threshold not taken from source role bit");

   a_oc_latch: assert property (
      syncOut[upms_pkg::LANE_OVERCURRENT] &&
      !syncPrev[upms_pkg::LANE_OVERCURRENT] |=> usbOvercurrentEvent ##1
      (usbIrq == !$past(usbOvercurrentMask)))
      else $error("overcurrent edge not latched or not signalled");

   a_oc_read_clear: assert property (
      rdIst && !ocRise |=> !usbOvercurrentEvent &&
         regRdData[upms_pkg::OVERCURRENT_BIT] == $past(usbOvercurrentEvent))
      else $error("overcurrent read did not return and clear");

   a_usb_irq_mask: assert property (
      usbOvercurrentMask [*2] |-> !usbIrq)
      else $error("masked overcurrent raised usb interrupt");

   a_fb_both_edges: assert property (
      $changed(syncOut[upms_pkg::LANE_WALL_PRESENT_FEEDBACK]) |=> presenceChange[1])
      else $error("wall presence change not latched");

   a_cmp_read_clear: assert property (
      rdCmp && fbToggle == 3'h0 |=> presenceChange == 3'h0)
      else $error("change bits not cleared by read");

   a_supply_irq: assert property (
      supplyChangeIrq == $past(|(presenceChange & ~presenceMask)))
      else $error("supply interrupt does not match unmasked status");

   c_oc_then_read: cover property (
      ocRise ##[1:20] rdIst);

   c_supply_irq: cover property (
      $rose(supplyChangeIrq));

   c_source_high: cover property (
      usbPowerSourceRole && currentLimitHigh);

   c_masked_latch: cover property (
      usbOvercurrentMask && usbOvercurrentEvent);

endmodule
